/* File: design/ssp_pkg.sv */
// package for the shadow pipeline register: widths, sync depth, bus structs
// assumes the user side of the block runs on one core clock
package ssp_pkg;
  localparam int unsigned SSP_WIDTH    = 8;
  localparam int unsigned SSP_SYNC_LEN = 3;
  localparam int unsigned SSP_MSB      = SSP_WIDTH - 1;

  typedef logic [SSP_WIDTH-1:0] ssp_byte_t;

  // three-state byte: value plus enable (high while this block drives it)
  typedef struct packed {
    ssp_byte_t data;
    logic      oe;
  } ssp_tri_t;

  // external control levels seen after synchronisation
  typedef struct packed {
    logic mode;
    logic serial_in;
    logic oe_n;
  } ssp_ctrl_t;

  localparam ssp_byte_t SSP_ZERO = 8'h00;
endpackage

/* File: design/ssp_edge_sync.sv */
// three-stage synchroniser with rising-edge detect for one async pin
// assumes the pin is asynchronous to i_core_clk
`timescale 1ns/1ps
module ssp_edge_sync
  import ssp_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_reset,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_rise
);
  logic [SSP_SYNC_LEN-1:0] sync_reg;
  logic                    level_reg;

  // a change counts once the second and third stages agree
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sync_reg  <= '0;
      level_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[SSP_SYNC_LEN-2:0], i_pin};
      if (sync_reg[1] == sync_reg[2]) begin
        level_reg <= sync_reg[2];
      end
    end
  end

  assign o_level = level_reg;
  assign o_rise  = (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !level_reg;
endmodule

/* File: design/ssp_shadow_reg.sv */
// eight-bit pipeline register with shadow shift register
// assumes both device clocks arrive as async pins sampled by i_core_clk,
// and the other party drives mode and both clocks of a chain in common
`timescale 1ns/1ps

// What this block does
// - two eight-bit stages: output register and shadow shift register
// - mode low, system clock rise: output register loads input bus
// - mode low, diagnostic rise: shadow shifts toward bit 7, serial out bit 7
// - mode low, both clocks rise: load and shift happen together
// - mode high, system clock rise: output takes shadow; serial out follows in
// - mode high, serial in low, diagnostic rise: shadow captures output bus
// - chain through serial out to serial in; mode and clocks shared
// - mode high, serial in low, both rise: registers swap contents
// - mode high, serial in high, diagnostic rise: hold, drive input bus
module ssp_shadow_reg
  import ssp_pkg::*;
(
  input  wire logic      i_core_clk,
  input  wire logic      i_reset,
  input  wire logic      i_system_clock,
  input  wire logic      i_diagnostic_clock,
  input  wire logic      i_mode,
  input  wire logic      i_serial_in,
  input  wire logic      i_output_enable_n,
  input  wire ssp_byte_t i_input_bus,
  output ssp_byte_t      o_input_bus,
  output logic           o_input_bus_oe,
  output ssp_byte_t      o_output_bus,
  output logic           o_output_bus_oe,
  output logic           o_serial_out
);

  // ---------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------
  logic      sys_rise;
  logic      diag_rise;
  ssp_ctrl_t ctrl;
  ssp_byte_t bus_sync1_reg;
  ssp_byte_t bus_sync2_reg;
  ssp_byte_t bus_sync3_reg;
  ssp_byte_t bus_level_reg;

  ssp_edge_sync u_sys_sync (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_pin      (i_system_clock),
    .o_level    (),
    .o_rise     (sys_rise)
  );

  ssp_edge_sync u_diag_sync (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_pin      (i_diagnostic_clock),
    .o_level    (),
    .o_rise     (diag_rise)
  );

  ssp_edge_sync u_mode_sync (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_pin      (i_mode),
    .o_level    (ctrl.mode),
    .o_rise     ()
  );

  ssp_edge_sync u_sin_sync (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_pin      (i_serial_in),
    .o_level    (ctrl.serial_in),
    .o_rise     ()
  );

  ssp_edge_sync u_oe_sync (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_pin      (i_output_enable_n),
    .o_level    (ctrl.oe_n),
    .o_rise     ()
  );

  // data bus shares the clocks' sync depth so it lines up with the edges
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      bus_sync1_reg <= SSP_ZERO;
      bus_sync2_reg <= SSP_ZERO;
      bus_sync3_reg <= SSP_ZERO;
      bus_level_reg <= SSP_ZERO;
    end else begin
      bus_sync1_reg <= i_input_bus;
      bus_sync2_reg <= bus_sync1_reg;
      bus_sync3_reg <= bus_sync2_reg;
      if (bus_sync2_reg == bus_sync3_reg) begin
        bus_level_reg <= bus_sync3_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // storage stages
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_IDLE,
    OP_LOAD,
    OP_SHIFT,
    OP_LOAD_SHIFT,
    OP_TRANSFER,
    OP_CAPTURE,
    OP_SWAP,
    OP_WRITE_BACK
  } ssp_op_t;

  ssp_op_t   op_sel;
  ssp_byte_t out_reg;
  ssp_byte_t shadow_reg;
  logic      drive_back_reg;

  // ---------------------------------------------------------------
  // operation decode
  // ---------------------------------------------------------------
  // a joint rise for load and shift, or for the swap, gets a code of its
  // own, so both read the old contents and never race each other
  always_comb begin
    op_sel = OP_IDLE;
    if (!ctrl.mode) begin
      unique case ({sys_rise, diag_rise})
        2'h0: op_sel = OP_IDLE;
        2'h1: op_sel = OP_SHIFT;
        2'h2: op_sel = OP_LOAD;
        2'h3: op_sel = OP_LOAD_SHIFT;
      endcase
    end else if (!ctrl.serial_in) begin
      unique case ({sys_rise, diag_rise})
        2'h0: op_sel = OP_IDLE;
        2'h1: op_sel = OP_CAPTURE;
        2'h2: op_sel = OP_TRANSFER;
        2'h3: op_sel = OP_SWAP;
      endcase
    end else begin
      // a system rise here breaks the steady-clock rule; alone it transfers, with a diagnostic rise write-back wins
      unique case ({sys_rise, diag_rise})
        2'h0: op_sel = OP_IDLE;
        2'h1: op_sel = OP_WRITE_BACK;
        2'h2: op_sel = OP_TRANSFER;
        2'h3: op_sel = OP_WRITE_BACK;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // output register
  // ---------------------------------------------------------------
  // holds across a lone diagnostic rise, so scan work never disturbs
  // the pipeline output
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      out_reg <= SSP_ZERO;
    end else begin
      unique case (op_sel)
        OP_LOAD, OP_LOAD_SHIFT: begin
          out_reg <= bus_level_reg;
        end
        OP_TRANSFER, OP_SWAP: begin
          out_reg <= shadow_reg;
        end
        OP_IDLE, OP_SHIFT, OP_CAPTURE, OP_WRITE_BACK: begin
          out_reg <= out_reg;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // shadow shift register
  // ---------------------------------------------------------------
  // both registers read the other's old value, so a swap needs no temp
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      shadow_reg <= SSP_ZERO;
    end else begin
      unique case (op_sel)
        OP_SHIFT, OP_LOAD_SHIFT: begin
          shadow_reg <= {shadow_reg[SSP_MSB-1:0], ctrl.serial_in};
        end
        OP_CAPTURE, OP_SWAP: begin
          shadow_reg <= out_reg;
        end
        OP_IDLE, OP_LOAD, OP_TRANSFER, OP_WRITE_BACK: begin
          shadow_reg <= shadow_reg;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // write-back drive
  // ---------------------------------------------------------------
  // starts on a diagnostic rise with mode and serial in high, and ends
  // as soon as either drops; the shadow holds, but a system rise still loads the output register from it
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      drive_back_reg <= 1'b0;
    end else if (!(ctrl.mode && ctrl.serial_in)) begin
      drive_back_reg <= 1'b0;
    end else if (op_sel == OP_WRITE_BACK) begin
      drive_back_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_output_bus    = out_reg;
  assign o_output_bus_oe = !ctrl.oe_n;
  assign o_input_bus     = shadow_reg;
  assign o_input_bus_oe  = drive_back_reg;
  // chain tap: pass-through in mode high keeps a long chain short
  assign o_serial_out    = ctrl.mode ? ctrl.serial_in
                                     : shadow_reg[SSP_MSB];
endmodule

/* File: bench/ssp_shadow_reg_assertions.sv */
// checker bound to the ports of ssp_shadow_reg
// assumes pins stay steady six core cycles around each clock rise
`timescale 1ns/1ps
module ssp_chk
  import ssp_pkg::*;
(
  input wire logic      i_core_clk,
  input wire logic      i_reset,
  input wire logic      i_system_clock,
  input wire logic      i_diagnostic_clock,
  input wire logic      i_mode,
  input wire logic      i_serial_in,
  input wire logic      i_output_enable_n,
  input wire ssp_byte_t i_input_bus,
  input wire ssp_byte_t o_input_bus,
  input wire logic      o_input_bus_oe,
  input wire ssp_byte_t o_output_bus,
  input wire logic      o_output_bus_oe,
  input wire logic      o_serial_out
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // lone rises only: a joint rise loads and shifts, swaps or writes back; the bench judges the first two
  sequence s_sys; $rose(i_system_clock) && !$rose(i_diagnostic_clock);
  endsequence
  sequence s_dg; $rose(i_diagnostic_clock) && !$rose(i_system_clock);
  endsequence
  property p_load;
    s_sys ##0 !i_mode |-> ##[2:6] o_output_bus == i_input_bus; endproperty
  a_load: assert property (p_load) else $error("load");
  property p_shift;
    s_dg ##0 !i_mode |-> ##[2:6] o_input_bus[0] == i_serial_in; endproperty
  a_shift: assert property (p_shift) else $error("shift");
  property p_sout;
    (!i_mode)[*6] |-> o_serial_out == o_input_bus[7]; endproperty
  a_sout: assert property (p_sout) else $error("sout");
  property p_xfer;
    s_sys ##0 i_mode |-> ##[2:6] o_output_bus == o_input_bus; endproperty
  a_xfer: assert property (p_xfer) else $error("xfer");
  property p_follow;
    (i_mode && $stable(i_serial_in))[*6] |-> o_serial_out == i_serial_in;
  endproperty
  a_follow: assert property (p_follow) else $error("follow");
  property p_cap;
    s_dg ##0 (i_mode && !i_serial_in) |-> ##[2:6] o_input_bus == o_output_bus;
  endproperty
  a_cap: assert property (p_cap) else $error("capture");
  property p_wb;
    s_dg ##0 (i_mode && i_serial_in) |-> ##[2:6] o_input_bus_oe; endproperty
  a_wb: assert property (p_wb) else $error("writeback");
  property p_oe;
    $stable(i_output_enable_n)[*6] |-> o_output_bus_oe == !i_output_enable_n;
  endproperty
  a_oe: assert property (p_oe) else $error("enable");
endmodule
bind ssp_shadow_reg ssp_chk u_chk (.*);

/* File: bench/ssp_far_end.sv */
// far-end sequencer: mode, serial in and both device clocks
// assumes one caller at a time, starting after reset
`timescale 1ns/1ps
module ssp_far_end (
  input  wire logic i_core_clk,
  output logic      o_sys,
  output logic      o_dg,
  output logic      o_mode,
  output logic      o_sin
);
  initial {o_sys, o_dg, o_mode, o_sin} = 4'h0;
  // one 125 ns clock period; a clock not asked for stays low
  task automatic op(input logic m, s, a, b);
    @(posedge i_core_clk) #1 {o_mode, o_sin} = {m, s};
    repeat (6) @(posedge i_core_clk);
    #1 {o_sys, o_dg} = {a, b};
    #62.5 {o_sys, o_dg} = 2'h0;
    #62.5 repeat (6) @(posedge i_core_clk);
    #1;
  endtask
endmodule

/* File: bench/testbench.sv */
// bench: scenario tasks on ssp_shadow_reg
// assumes ssp_far_end drives the clocks, mode and serial in
`timescale 1ns/1ps
module testbench
  import ssp_pkg::*;
;
  logic      i_core_clk = 0, i_reset = 1, i_output_enable_n = 0;
  logic      i_system_clock, i_diagnostic_clock, i_mode, i_serial_in;
  logic      o_input_bus_oe, o_output_bus_oe, o_serial_out;
  ssp_byte_t i_input_bus, o_input_bus, o_output_bus, d = 8'ha5;
  int        err_total, checked, cyc;
  // bus pins carry the design's data while it drives them
  assign i_input_bus = (o_input_bus_oe === 1'b1) ? o_input_bus : d;
  ssp_shadow_reg uut (.*);
  ssp_far_end far (.i_core_clk, .o_sys(i_system_clock),
    .o_dg(i_diagnostic_clock), .o_mode(i_mode), .o_sin(i_serial_in));
  task automatic chk(input ssp_byte_t seen, exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("%0d checks %0d bad", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic t_path;
    ssp_byte_t sh = 8'h00;
    far.op(0, 0, 1, 0);
    chk(o_output_bus, 8'ha5);
    for (int i = 0; i < 8; i++) begin
      far.op(0, i[0], 0, 1);
      sh = {sh[6:0], i[0]};
      chk(o_input_bus, sh);
    end
    d = 8'h3c;
    far.op(0, 1, 1, 1);
    chk(o_output_bus, 8'h3c);
    chk(o_input_bus, 8'hab);
    chk({7'h0, o_serial_out}, 8'h01);
    $display("path done");
  endtask
  task automatic t_shadow;
    far.op(1, 1, 1, 0);
    chk(o_output_bus, 8'hab);
    chk({7'h0, o_serial_out}, 8'h01);
    d = 8'h96;
    far.op(0, 0, 1, 0);
    far.op(1, 0, 0, 1);
    chk(o_input_bus, 8'h96);
    chk(o_output_bus, 8'h96);
    d = 8'h0f;
    far.op(0, 0, 1, 0);
    far.op(1, 0, 1, 1);
    chk(o_output_bus, 8'h96);
    chk(o_input_bus, 8'h0f);
    d = 8'hc3;
    far.op(1, 1, 0, 1);
    chk(i_input_bus, 8'h0f);
    chk(o_output_bus, 8'h96);
    chk(o_input_bus, 8'h0f);
    chk({7'h0, o_output_bus_oe}, 8'h01);
    i_output_enable_n = 1;
    far.op(0, 0, 0, 0);
    chk({6'h0, o_input_bus_oe, o_output_bus_oe}, 8'h00);
    $display("shadow done");
  endtask
  initial forever #5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      print_verdict;
    end
  end
  initial begin
    repeat (16) @(posedge i_core_clk);
    #1 i_reset = 0;
    t_path;
    t_shadow;
    print_verdict;
  end
endmodule
